/* hw/fsd_regs.svh */
`ifndef FSD_REGS_SVH
`define FSD_REGS_SVH

// bus byte addresses
`define FSD_ADDR_PROG 8'h00
`define FSD_ADDR_WORD0 8'h04
`define FSD_ADDR_WORD5 8'h18
`define FSD_ADDR_STATUS 8'h1C

// control bit patterns of a programming word
`define FSD_CTRL_R0 3'h0
`define FSD_CTRL_R1 3'h1
`define FSD_CTRL_R2 3'h2
`define FSD_CTRL_R3 3'h3
`define FSD_CTRL_R4 3'h4
`define FSD_CTRL_R5 3'h5

// field positions
`define FSD_INT_HI 30
`define FSD_INT_LO 15
`define FSD_FRACTIONAL_NUMERATOR_HI 14
`define FSD_FRACTIONAL_NUMERATOR_LO 3
`define FSD_MOD_HI 14
`define FSD_MOD_LO 3
`define FSD_DBL_BIT 25
`define FSD_HALF_BIT 24
`define FSD_RCNT_HI 23
`define FSD_RCNT_LO 14
`define FSD_DBUF_BIT 13
`define FSD_CP_HI 12
`define FSD_CP_LO 9
`define FSD_PD_BIT 5
`define FSD_CRST_BIT 3
`define FSD_SLIP_EN_BIT 18
`define FSD_CDMODE_HI 16
`define FSD_CDMODE_LO 15
`define FSD_CDVAL_HI 14
`define FSD_CDVAL_LO 3
`define FSD_DIVSEL_HI 22
`define FSD_DIVSEL_LO 20
`define FSD_LDPIN_HI 23
`define FSD_LDPIN_LO 22

// reset values, counts and response codes
`define FSD_WORD_RESET 32'h0000_0000
`define FSD_MAX_CELLS 3'h7
`define FSD_RESP_OKAY 2'h0
`define FSD_RESP_SLVERR 2'h2

`endif

/* hw/fsd_pkg.sv */
package fsd_pkg;
  // slip reduction sequencer states
  typedef enum logic [1:0] {
    SLIP_IDLE = 2'b00,
    SLIP_RAMP = 2'b01,
    SLIP_UNWIND = 2'b10
  } fsd_slip_state_type;

  // clock divider modes
  typedef enum logic [1:0] {
    CDIV_OFF = 2'b00,
    CDIV_FASTLOCK = 2'b01,
    CDIV_RESYNC = 2'b10
  } fsd_cdiv_mode_type;

  // lock pin behaviours
  typedef enum logic [1:0] {
    LDPIN_LOW = 2'b00,
    LDPIN_DIGITAL = 2'b01,
    LDPIN_LOW_ALT = 2'b10,
    LDPIN_HIGH = 2'b11
  } fsd_ldpin_mode_type;
endpackage

/* hw/fsd_ref_path.sv */
`timescale 1ns/10ps
module fsd_ref_path (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // reference and settings
  input wire logic ref_in,
  input wire logic doubler_en,
  input wire logic halve_en,
  input wire logic [9:0] r_count,
  input wire logic hold_reset,
  // comparison clock
  output logic comparison_tick,
  output logic comparison_clk
);
  logic ref_prev_reg;
  logic [9:0] cnt_reg;
  logic [9:0] cnt_next;
  logic tog_reg;
  logic tick_reg;
  logic clk_reg;
  wire active_edge;
  wire [9:0] r_eff;
  wire div_pulse;

  // doubler makes both edges active, else falling only
  assign active_edge = doubler_en ? (ref_in ^ ref_prev_reg) : (ref_prev_reg & ~ref_in);
  // ratio zero is treated as one
  assign r_eff = (r_count == 10'h000) ? 10'h001 : r_count;
  // at or past the end count wraps at once, so a smaller ratio never stalls
  assign div_pulse = active_edge && (cnt_reg >= r_eff - 10'h001);
  assign cnt_next = div_pulse ? 10'h000 : cnt_reg + 10'h001;

  // edge detect, ten-bit counter, halving toggle
  always_ff @(posedge aclk) begin
    if (!aresetn || hold_reset) begin
      ref_prev_reg <= 1'b0;
      cnt_reg <= 10'h000;
      tog_reg <= 1'b0;
      tick_reg <= 1'b0;
      clk_reg <= 1'b0;
    end else begin
      ref_prev_reg <= ref_in;
      if (active_edge) begin
        cnt_reg <= cnt_next;
      end
      if (div_pulse) begin
        tog_reg <= ~tog_reg;
      end
      tick_reg <= halve_en ? (div_pulse & ~tog_reg) : div_pulse;
      clk_reg <= halve_en ? (tog_reg ^ div_pulse) : div_pulse;
    end
  end

  assign comparison_tick = tick_reg;
  assign comparison_clk = clk_reg;
endmodule

/* hw/fsd_synth_ctrl.sv */
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "fsd_regs.svh"
module fsd_synth_ctrl (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // loop side inputs
  input wire logic ref_in,
  input wire logic lock_detect_in,
  input wire logic slip_imminent,
  input wire logic target_passed,
  input wire logic tune_up,
  // divider settings
  output logic [15:0] integer_value,
  output logic [11:0] fractional_numerator,
  output logic [11:0] fractional_modulus,
  output logic [4:0] output_div_ratio,
  // comparison clock and lock pin
  output logic comparison_clk,
  output fsd_pkg::fsd_ldpin_mode_type lock_pin_mode,
  output logic lock_pin,
  // charge pump
  output logic [6:0] extra_cell_en,
  output logic cell_source,
  output logic cell_sink,
  output logic [7:0] cp_current,
  // fast lock, resync and power down
  output logic wide_bandwidth,
  output logic fastlock_switch_pin_out,
  output logic fastlock_switch_pin_oe_n,
  output logic resync_pulse,
  output logic powered_down
);
  import fsd_pkg::*;

  // control bits of a programming word
  function automatic logic [2:0] ctrl_of(input logic [31:0] w);
    ctrl_of = w[2:0];
  endfunction

  logic [31:0] word_reg [0:5];
  logic [2:0] div_sel_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  fsd_slip_state_type slip_state_reg;
  fsd_slip_state_type slip_state_next;
  logic [2:0] cells_reg;
  logic [2:0] cells_next;
  logic dir_up_reg;
  logic [11:0] fl_timer_reg;
  logic wide_reg;
  logic [23:0] sync_cnt_reg;
  logic sync_reg;
  logic lock_pin_reg;
  logic tick;
  logic cmp_clk;

  // decoded fields
  wire [31:0] w0 = word_reg[0];
  wire [31:0] w1 = word_reg[1];
  wire [31:0] w2 = word_reg[2];
  wire [31:0] w3 = word_reg[3];
  wire [31:0] w4 = word_reg[4];
  wire [31:0] w5 = word_reg[5];
  wire slip_en = w3[`FSD_SLIP_EN_BIT];
  wire [1:0] cdiv_mode = w3[`FSD_CDMODE_HI:`FSD_CDMODE_LO];
  wire [11:0] cdiv_value = w3[`FSD_CDVAL_HI:`FSD_CDVAL_LO];
  wire [11:0] modulus = w1[`FSD_MOD_HI:`FSD_MOD_LO];
  wire pd = w2[`FSD_PD_BIT];
  wire hold_reset = w2[`FSD_CRST_BIT] | pd;
  wire [1:0] ldpin = w5[`FSD_LDPIN_HI:`FSD_LDPIN_LO];
  wire [23:0] sync_period = 24'(cdiv_value) * 24'(modulus);

  // write channel decode
  wire do_write = aw_full_reg && w_full_reg && !bvalid_reg;
  wire wr_prog = (aw_addr_reg == `FSD_ADDR_PROG);
  wire wr_full_word = (w_strb_reg == 4'hF);
  wire [2:0] wr_ctrl = ctrl_of(w_data_reg);
  wire wr_accept = do_write && wr_prog && wr_full_word && (wr_ctrl <= `FSD_CTRL_R5);
  wire wr_r3 = wr_accept && (wr_ctrl == `FSD_CTRL_R3);
  wire wr_r5 = wr_accept && (wr_ctrl == `FSD_CTRL_R5);
  wire wr_r4 = wr_accept && (wr_ctrl == `FSD_CTRL_R4);
  wire wr_r0 = wr_accept && (wr_ctrl == `FSD_CTRL_R0);
  wire [11:0] new_cdval = w_data_reg[`FSD_CDVAL_HI:`FSD_CDVAL_LO];
  wire [1:0] new_mode = w_data_reg[`FSD_CDMODE_HI:`FSD_CDMODE_LO];

  // read channel decode
  wire rd_take = s_axi_arvalid && !rvalid_reg;
  wire rd_word = (s_axi_araddr >= `FSD_ADDR_WORD0) && (s_axi_araddr <= `FSD_ADDR_WORD5) &&
    (s_axi_araddr[1:0] == 2'h0);
  wire [2:0] rd_index = 3'((s_axi_araddr - `FSD_ADDR_WORD0) >> 2);
  wire rd_status = (s_axi_araddr == `FSD_ADDR_STATUS);
  wire [31:0] status_word = {11'h000, sync_reg, wide_reg, fl_timer_reg, dir_up_reg,
    cells_reg, slip_state_reg, lock_pin_reg};

  // handshakes
  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready = !w_full_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_full_reg) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
        aw_full_reg <= 1'b0;
      end
      if (s_axi_wvalid && !w_full_reg) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (do_write) begin
        w_full_reg <= 1'b0;
      end
    end
  end

  // write response, unmapped address answers slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `FSD_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_prog ? `FSD_RESP_OKAY : `FSD_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // read data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `FSD_RESP_OKAY;
    end else if (rd_take) begin
      rvalid_reg <= 1'b1;
      if (rd_word) begin
        rdata_reg <= word_reg[rd_index];
        rresp_reg <= `FSD_RESP_OKAY;
      end else if (rd_status) begin
        rdata_reg <= status_word;
        rresp_reg <= `FSD_RESP_OKAY;
      end else begin
        rdata_reg <= 32'h0000_0000;
        rresp_reg <= `FSD_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // programming words routed by their control bits
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_word
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          word_reg[gi] <= `FSD_WORD_RESET;
        end else if (wr_accept && (wr_ctrl == 3'(gi))) begin
          word_reg[gi] <= w_data_reg;
        end
      end
    end
  endgenerate

  // divider select, double buffered until register zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_sel_reg <= 3'h0;
    end else if (wr_r4 && !w2[`FSD_DBUF_BIT]) begin
      div_sel_reg <= w_data_reg[`FSD_DIVSEL_HI:`FSD_DIVSEL_LO];
    end else if (wr_r0 && w2[`FSD_DBUF_BIT]) begin
      div_sel_reg <= w4[`FSD_DIVSEL_HI:`FSD_DIVSEL_LO];
    end
  end

  // reference doubler, ten-bit counter, halving
  fsd_ref_path u_ref (
    .aclk(aclk),
    .aresetn(aresetn),
    .ref_in(ref_in),
    .doubler_en(w2[`FSD_DBL_BIT]),
    .halve_en(w2[`FSD_HALF_BIT]),
    .r_count(w2[`FSD_RCNT_HI:`FSD_RCNT_LO]),
    .hold_reset(hold_reset),
    .comparison_tick(tick),
    .comparison_clk(cmp_clk)
  );

  // slip sequencer next state
  always_comb begin
    slip_state_next = slip_state_reg;
    cells_next = cells_reg;
    case (slip_state_reg)
      SLIP_IDLE: begin
        if (slip_imminent) begin
          slip_state_next = SLIP_RAMP;
          cells_next = 3'h1;
        end
      end
      SLIP_RAMP: begin
        if (target_passed) begin
          slip_state_next = SLIP_UNWIND;
        end else if (slip_imminent && cells_reg != `FSD_MAX_CELLS) begin
          cells_next = cells_reg + 3'h1;
        end
      end
      SLIP_UNWIND: begin
        if (tick) begin
          cells_next = cells_reg - 3'h1;
          if (cells_reg == 3'h1) begin
            slip_state_next = SLIP_IDLE;
          end
        end
      end
      default: begin
        slip_state_next = SLIP_IDLE;
        cells_next = 3'h0;
      end
    endcase
  end

  // slip sequencer registers, disabled clears all cells
  always_ff @(posedge aclk) begin
    if (!aresetn || !slip_en || pd) begin
      slip_state_reg <= SLIP_IDLE;
      cells_reg <= 3'h0;
      dir_up_reg <= 1'b0;
    end else begin
      slip_state_reg <= slip_state_next;
      cells_reg <= cells_next;
      if (slip_state_reg == SLIP_IDLE && slip_imminent) begin
        dir_up_reg <= tune_up;
      end
    end
  end

  // thermometer of extra cells
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_cell
      assign extra_cell_en[gi] = (cells_reg > 3'(gi));
    end
  endgenerate
  assign cell_source = (cells_reg != 3'h0) && dir_up_reg;
  assign cell_sink = (cells_reg != 3'h0) && !dir_up_reg;

  // fast-lock timer in comparison periods
  always_ff @(posedge aclk) begin
    if (!aresetn || pd) begin
      fl_timer_reg <= 12'h000;
      wide_reg <= 1'b0;
    end else if (wr_r3) begin
      if (new_mode == CDIV_FASTLOCK) begin
        fl_timer_reg <= new_cdval;
        wide_reg <= (new_cdval != 12'h000);
      end else begin
        fl_timer_reg <= 12'h000;
        wide_reg <= 1'b0;
      end
    end else if (wide_reg && tick) begin
      fl_timer_reg <= fl_timer_reg - 12'h001;
      if (fl_timer_reg == 12'h001) begin
        wide_reg <= 1'b0;
      end
    end
  end

  // phase resync every divider value times modulus periods
  always_ff @(posedge aclk) begin
    if (!aresetn || pd || wr_r3 || cdiv_mode != CDIV_RESYNC) begin
      sync_cnt_reg <= 24'h000000;
      sync_reg <= 1'b0;
    end else if (tick) begin
      if (sync_cnt_reg + 24'h000001 >= sync_period) begin
        sync_cnt_reg <= 24'h000000;
        sync_reg <= (sync_period != 24'h000000);
      end else begin
        sync_cnt_reg <= sync_cnt_reg + 24'h000001;
        sync_reg <= 1'b0;
      end
    end else begin
      sync_reg <= 1'b0;
    end
  end

  // lock indicator pin behaviour
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_pin_reg <= 1'b0;
    end else begin
      case (fsd_ldpin_mode_type'(ldpin))
        LDPIN_DIGITAL: lock_pin_reg <= lock_detect_in;
        LDPIN_HIGH: lock_pin_reg <= 1'b1;
        default: lock_pin_reg <= 1'b0;
      endcase
    end
  end

  // divider values for the output frequency
  assign integer_value = w0[`FSD_INT_HI:`FSD_INT_LO];
  assign fractional_numerator = w0[`FSD_FRACTIONAL_NUMERATOR_HI:`FSD_FRACTIONAL_NUMERATOR_LO];
  assign fractional_modulus = modulus;
  assign output_div_ratio = 5'h01 << div_sel_reg[2:0];

  // pins and charge pump current
  assign comparison_clk = cmp_clk;
  assign lock_pin_mode = fsd_ldpin_mode_type'(ldpin);
  assign lock_pin = lock_pin_reg;
  assign cp_current = wide_reg ? {w2[`FSD_CP_HI:`FSD_CP_LO], 4'h0} :
    {4'h0, w2[`FSD_CP_HI:`FSD_CP_LO]};
  assign wide_bandwidth = wide_reg;
  assign fastlock_switch_pin_out = 1'b0;
  assign fastlock_switch_pin_oe_n = !wide_reg;
  assign resync_pulse = sync_reg;
  assign powered_down = pd;
endmodule

/* sim/fsd_loop_model.sv */
`timescale 1ns/10ps
module fsd_loop_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bench commands
  input wire logic slip_req,
  input wire logic pass_req,
  input wire logic up_req,
  input wire logic lock_req,
  // loop side signals
  output logic ref_in,
  output logic slip_imminent,
  output logic target_passed,
  output logic tune_up,
  output logic lock_detect_in
);
  logic [1:0] ref_cnt_reg;
  // reference at a quarter of aclk keeps the compare rate low
  always_ff @(posedge aclk) begin
    ref_cnt_reg <= aresetn ? ref_cnt_reg + 2'h1 : 2'h0;
  end
  assign ref_in = ref_cnt_reg[1];
  // one-cycle slip and overshoot events
  always_ff @(posedge aclk) begin
    slip_imminent <= slip_req;
    target_passed <= pass_req;
    tune_up <= up_req;
    lock_detect_in <= lock_req;
  end
endmodule

/* sim/fsd_synth_ctrl_checker.sv */
`timescale 1ns/10ps
module fsd_synth_ctrl_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // loop outputs
  input wire logic lock_detect_in,
  input wire logic powered_down,
  input fsd_pkg::fsd_ldpin_mode_type lock_pin_mode,
  input wire logic lock_pin,
  input wire logic [6:0] extra_cell_en,
  input wire logic cell_source,
  input wire logic cell_sink,
  input wire logic [7:0] cp_current,
  input wire logic wide_bandwidth,
  input wire logic fastlock_switch_pin_oe_n,
  input wire logic resync_pulse
);
  import fsd_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // timer write in fast-lock mode, then wide bandwidth
  sequence s_fl_write;
    s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'h00 && s_axi_wvalid && s_axi_wready
      && s_axi_wstrb == 4'hF && s_axi_wdata[2:0] == 3'h3 && s_axi_wdata[16:15] == 2'h1
      && s_axi_wdata[14:3] != 12'h000 && !powered_down;
  endsequence
  sequence s_wide_on;
    ##[1:2] wide_bandwidth;
  endsequence
  chk_fastlock_start: assert property (s_fl_write |-> s_wide_on)
    else $error("wide mode not entered");
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_cell_therm: assert property (((extra_cell_en + 7'h01) & extra_cell_en) == 7'h00)
    else $error("cells not contiguous");
  chk_cell_step: assert property (!$stable(extra_cell_en) && extra_cell_en != 7'h00
    |-> extra_cell_en == {$past(extra_cell_en[5:0]), 1'b1}
    || extra_cell_en == $past(extra_cell_en) >> 1)
    else $error("cells changed by more than one");
  chk_cell_dir: assert property ((cell_source || cell_sink) == (extra_cell_en != 7'h00)
    && !(cell_source && cell_sink))
    else $error("cell direction wrong");
  chk_switch_wide: assert property (fastlock_switch_pin_oe_n == !wide_bandwidth)
    else $error("switch pin not tied to wide mode");
  chk_cp_boost: assert property ($rose(wide_bandwidth)
    |-> cp_current == {$past(cp_current[3:0]), 4'h0})
    else $error("pump current not boosted");
  chk_lock_level: assert property ($stable(lock_pin_mode) && lock_pin_mode != LDPIN_DIGITAL
    |-> lock_pin == (lock_pin_mode == LDPIN_HIGH))
    else $error("lock pin level wrong");
  chk_lock_follow: assert property (lock_pin_mode == LDPIN_DIGITAL
    && $past(lock_pin_mode) == LDPIN_DIGITAL |-> lock_pin == $past(lock_detect_in))
    else $error("lock pin not following");
  chk_resync_single: assert property (resync_pulse |=> !resync_pulse)
    else $error("resync pulse too long");
endmodule
bind fsd_synth_ctrl fsd_synth_ctrl_checker u_checker (.*);

/* sim/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import fsd_pkg::*;
  logic aclk, aresetn, slip_req, pass_req, up_req, lock_req;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic ref_in, lock_detect_in, slip_imminent, target_passed, tune_up;
  logic [15:0] integer_value;
  logic [11:0] fractional_numerator, fractional_modulus;
  logic [4:0] output_div_ratio;
  logic [6:0] extra_cell_en;
  logic [7:0] cp_current;
  fsd_ldpin_mode_type lock_pin_mode;
  logic comparison_clk, lock_pin, cell_source, cell_sink, wide_bandwidth, resync_pulse;
  logic fastlock_switch_pin_out, fastlock_switch_pin_oe_n, powered_down;
  logic [31:0] word [6]; // shadow of the programming words
  int n_errors, tests_run, i, k, cnt, hi, rs, m, f, n, d, e;
  int cfg [5][3] = '{'{0, 0, 1}, '{0, 0, 3}, '{1, 0, 2}, '{0, 1, 1}, '{1, 1, 3}};
  fsd_synth_ctrl DUT (.*);
  fsd_loop_model u_loop (.*);
  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // bounded wait, a hang counts as a mismatch
  task automatic guard(inout int c);
    c++;
    if (c > 400) begin
      check(32'h0, 32'h1);
      end_of_test();
    end
  endtask
  function automatic bit near(int v, int ex, int t);
    return v >= ex - t && v <= ex + t;
  endfunction
  // one register bus transfer, read or write
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] dt);
    bit aok, wok, rok, dn;
    int c;
    c = 0;
    dn = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= dt;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    while (!dn) begin
      @(negedge aclk);
      guard(c);
      aok = s_axi_awvalid && s_axi_awready;
      wok = s_axi_wvalid && s_axi_wready;
      rok = s_axi_arvalid && s_axi_arready;
      dn = w ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata;
      r = w ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (aok) s_axi_awvalid <= 1'b0;
      if (wok) s_axi_wvalid <= 1'b0;
      if (rok) s_axi_arvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic [1:0] er);
    bus(1'b1, a, dt);
    check(32'(r), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    bus(1'b0, a, 32'h0);
    check(q, ex);
    check(32'(r), 32'(er));
  endtask
  task automatic prog(input int idx, input logic [31:0] fld);
    word[idx] = fld | 32'(idx);
    wr(8'h00, word[idx], 2'h0);
  endtask
  // slip or overshoot events from the loop
  task automatic kick(input bit s, input int times, input bit up);
    repeat (times) begin
      @(posedge aclk);
      slip_req <= s;
      pass_req <= !s;
      up_req <= up;
      @(posedge aclk);
      slip_req <= 1'b0;
      pass_req <= 1'b0;
      repeat (2) @(posedge aclk);
    end
    @(negedge aclk);
  endtask
  task automatic watch(input int cyc);
    logic prev;
    cnt = 0;
    hi = 0;
    rs = 0;
    prev = comparison_clk;
    repeat (cyc) begin
      @(negedge aclk);
      cnt += int'(comparison_clk && !prev);
      hi += int'(comparison_clk);
      rs += int'(resync_pulse);
      prev = comparison_clk;
    end
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, slip_req, pass_req, up_req, lock_req} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    i = $urandom(96);
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check(32'(output_div_ratio), 32'h1);
    check(32'(fastlock_switch_pin_oe_n), 32'h1);
    $display("reset test done");
    m = 2 + $urandom % 4094;
    f = $urandom % m;
    n = 23 + $urandom % 60000;
    d = $urandom % 5;
    prog(5, 32'h1 << 22);
    prog(4, 32'(d) << 20);
    prog(3, 32'h0);
    prog(2, 32'h1 << 14 | 32'h5 << 9);
    prog(1, 32'(m) << 3);
    prog(0, 32'(n) << 15 | 32'(f) << 3);
    for (k = 0; k < 6; k++) rd(8'(4 + 4 * k), word[k], 2'h0);
    check(32'(integer_value), 32'(n));
    check(32'(fractional_numerator), 32'(f));
    check(32'(fractional_modulus), 32'(m));
    check(32'(output_div_ratio), 32'h1 << d);
    wr(8'h1C, 32'h5, 2'h2);
    rd(8'h24, 32'h0, 2'h2);
    $display("programming test done");
    for (k = 0; k < 8; k++) begin
      if (k % 2 == 0) prog(5, 32'(k / 2) << 22);
      @(posedge aclk);
      lock_req <= 1'($urandom);
      repeat (4) @(negedge aclk);
      check(32'(lock_pin_mode), 32'(k / 2));
      check(32'(lock_pin), 32'(k / 2 == 3 || (k / 2 == 1 && lock_req)));
    end
    $display("lock pin test done");
    for (k = 0; k < 5; k++) begin
      prog(2, 32'(cfg[k][0]) << 25 | 32'(cfg[k][1]) << 24 | 32'(cfg[k][2]) << 14);
      watch(40);
      watch(480);
      e = 480 * (1 + cfg[k][0]) / (4 * cfg[k][2] * (1 + cfg[k][1]));
      check(32'(near(cnt, e, 1)), 32'h1);
      if (cfg[k][1] == 1) check(32'(near(hi, 240, 8)), 32'h1);
    end
    $display("reference test done");
    prog(2, 32'h1 << 14 | 32'h5 << 9);
    prog(3, 32'h1 << 15 | 32'd6 << 3);
    check(32'(wide_bandwidth), 32'h1);
    check(32'(cp_current), 32'h50);
    check(32'(fastlock_switch_pin_out), 32'h0);
    repeat (12) @(negedge aclk);
    prog(3, 32'h1 << 15 | 32'd6 << 3);
    i = 0;
    while (wide_bandwidth) begin
      @(negedge aclk);
      guard(i);
    end
    check(32'(near(i, 22, 5)), 32'h1);
    check(32'(cp_current), 32'h5);
    check(32'(fastlock_switch_pin_oe_n), 32'h1);
    prog(3, 32'h1 << 15 | 32'd100 << 3);
    prog(3, 32'h0);
    check(32'(wide_bandwidth), 32'h0);
    prog(1, 32'h2 << 3);
    prog(3, 32'h2 << 15 | 32'h3 << 3);
    watch(240);
    check(32'(near(rs, 10, 1)), 32'h1);
    prog(3, 32'h0);
    watch(100);
    check(32'(rs), 32'h0);
    $display("fast lock test done");
    prog(2, 32'h1 << 24 | 32'h1 << 14 | 32'h5 << 9);
    prog(3, 32'h1 << 18);
    kick(1'b1, 3, 1'b1);
    check(32'(extra_cell_en), 32'h07);
    check(32'(cell_source), 32'h1);
    kick(1'b1, 6, 1'b1);
    check(32'(extra_cell_en), 32'h7F);
    kick(1'b0, 1, 1'b1);
    i = 0;
    while (extra_cell_en != 7'h00) begin
      @(negedge aclk);
      guard(i);
    end
    check(32'(near(i, 52, 8)), 32'h1);
    kick(1'b1, 2, 1'b0);
    check(32'(extra_cell_en), 32'h03);
    check(32'(cell_sink), 32'h1);
    prog(3, 32'h0);
    @(negedge aclk);
    check(32'(extra_cell_en), 32'h00);
    kick(1'b1, 2, 1'b0);
    check(32'(extra_cell_en), 32'h00);
    $display("slip test done");
    prog(2, 32'h1 << 14 | 32'h1 << 5);
    @(negedge aclk);
    check(32'(powered_down), 32'h1);
    watch(40);
    check(32'(cnt), 32'h0);
    $display("power down test done");
    end_of_test();
  end
endmodule
